// *** inc/lds_pkg.sv ***
// Purpose: shared constants and types for the LED driver serial register port
// Assumes: 10 MHz system clock, bus pins sampled through two flip-flops
// Notes: register offsets are pointer values carried in the command byte
package lds_pkg;
  // Device address, upper six bits fixed
  localparam logic [5:0] LDS_ADDR_UPPER = 6'h1C;
  // Register pointer values
  localparam logic [7:0] LDS_REG_NOP = 8'h00;
  localparam logic [7:0] LDS_REG_DECODE = 8'h01;
  localparam logic [7:0] LDS_REG_BRIGHT = 8'h02;
  localparam logic [7:0] LDS_REG_LIMIT = 8'h03;
  localparam logic [7:0] LDS_REG_CONFIG = 8'h04;
  localparam logic [7:0] LDS_REG_RSVD = 8'h05;
  localparam logic [7:0] LDS_REG_PORTIO = 8'h06;
  localparam logic [7:0] LDS_REG_LAMP = 8'h07;
  localparam logic [7:0] LDS_REG_KEYSET = 8'h08;
  localparam logic [7:0] LDS_REG_KEYDN = 8'h0C;
  localparam logic [7:0] LDS_REG_DIGIT0 = 8'h20;
  localparam logic [7:0] LDS_REG_DIGIT1 = 8'h21;
  localparam logic [7:0] LDS_REG_DIGIT2 = 8'h22;
  localparam logic [7:0] LDS_REG_DIGIT3 = 8'h23;
  localparam logic [7:0] LDS_REG_DISCRETE = 8'h24;
  localparam logic [7:0] LDS_PTR_TOP = 8'h7F;
  // Reset values
  localparam logic [7:0] LDS_RST_DECODE = 8'h00;
  localparam logic [7:0] LDS_RST_BRIGHT = 8'h04;
  localparam logic [7:0] LDS_RST_LIMIT = 8'h03;
  localparam logic [7:0] LDS_RST_CONFIG = 8'h00;
  localparam logic [7:0] LDS_RST_PORTIO = 8'h80;
  localparam logic [7:0] LDS_RST_LAMP = 8'h00;
  localparam logic [7:0] LDS_RST_DIGIT = 8'h00;
  localparam logic [7:0] LDS_RST_PTR = 8'h00;
  // Field positions
  localparam int LDS_HEX_MSB = 3;
  localparam int LDS_SEG_MSB = 6;
  // Receive FIFO shape
  localparam int LDS_FIFO_W = 9;
  localparam int LDS_FIFO_D = 4;

  // Protocol states
  typedef enum logic [2:0] {
    LDS_IDLE, LDS_ADDR, LDS_ACK, LDS_WRITE, LDS_READ, LDS_MACK, LDS_SKIP
  } lds_state_t;

  // Received byte with a flag marking the command byte
  typedef struct packed {
    logic is_cmd;
    logic [7:0] data;
  } lds_rx_t;

  // Register file contents
  typedef struct packed {
    logic [7:0] decode;
    logic [7:0] bright;
    logic [7:0] limit;
    logic [7:0] config_r;
    logic [7:0] portio;
    logic [7:0] lamp;
    logic [3:0][7:0] digit;
    logic [7:0] discrete;
  } lds_regs_t;
endpackage

// *** design/lds_fifo.sv ***
// Purpose: small synchronous FIFO with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty derived from an occupancy count
module lds_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lds_fifo_st_t;
  lds_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;

  assign o_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign o_valid = (s_q.cnt != '0);
  assign o_data = mem_q[s_q.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + AW'(1);
    if (pop) s_d.rp = s_q.rp + AW'(1);
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; occupancy guards reads
  always_ff @(posedge i_clk) begin
    if (push) mem_q[s_q.wp] <= i_data;
  end
endmodule

// *** design/lds_port.sv ***
// Purpose: 2-wire serial slave port and register file of an LED display driver
// Assumes: bus pins asynchronous to i_clk; bus well below the 10 MHz clock
// Notes: written bytes pass a 4-entry FIFO before the register file
//
// Overview of operation
// - Idle bus has both lines high; device never pulls data while idle.
// - Data falling while clock high is a start; always restarts reception.
// - Data rising while clock high is a stop; device releases and waits.
// - Transmitter changes data only while clock is low.
// - Clock only sampled; data driven open-drain, low or released.
// - Transfer is start, address with direction, data bytes, stop.
// - Receiver pulls data low on ninth clock; device acks writes.
// - Eighth bit after address: low writes, high reads.
// - Address upper six bits 011100; lowest bit set by build option.
// - First written byte loads pointer; stop after it stores only that.
// - First data byte goes to the register the pointer selects.
// - Pointer increments after each data byte, holding at 0x7F.
// - Reads start at the stored pointer and increment the same way.
// - Writes to key status registers ignored; pointer still advances.
// - Digit registers drive segments a to g from bits 6 to 0.
// - Discrete register bit n drives segment line n.
// - Without decode a one lights a segment, a zero turns it off.
// - With decode, only low four bits select a hex character.
module lds_port
  import lds_pkg::*;
#(
  parameter bit ADDRESS_OPTION_BIT = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Key status from the scanner
  input wire logic [7:0] i_key_settled,
  input wire logic [7:0] i_key_down,
  // Display outputs
  output logic [3:0][6:0] o_digit_seg,
  output logic [7:0] o_discrete_led,
  output logic [7:0] o_brightness,
  output logic [7:0] o_digit_limit,
  output logic [7:0] o_config,
  output logic [7:0] o_port_io,
  output logic [7:0] o_lamp_test
);
  // Whole module state
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    lds_state_t st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic first;
    logic rd;
    logic oe;
    logic [7:0] ptr;
    lds_regs_t regs;
    logic [3:0][6:0] seg;
    logic [7:0] disc;
  } lds_st_t;
  lds_st_t s_q, s_d;

  // FIFO wiring
  lds_rx_t fin, fout;
  logic f_valid, f_ready, d_valid;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [6:0] own_addr;
  logic [7:0] rd_byte;

  lds_fifo #(.WIDTH(LDS_FIFO_W), .DEPTH(LDS_FIFO_D)) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_valid(f_valid),
    .i_data(fin),
    .o_ready(f_ready),
    .o_valid(d_valid),
    .o_data(fout),
    .i_ready(1'b1)
  );

  // Bus events from the second synchroniser stage onward
  assign scl_rise = s_q.scl_s[1] && !s_q.scl_p;
  assign scl_fall = !s_q.scl_s[1] && s_q.scl_p;
  assign start_c = s_q.scl_s[1] && s_q.scl_p && s_q.sda_p && !s_q.sda_s[1];
  assign stop_c = s_q.scl_s[1] && s_q.scl_p && !s_q.sda_p && s_q.sda_s[1];
  assign own_addr = {LDS_ADDR_UPPER, ADDRESS_OPTION_BIT};

  // Read data mux; unmapped locations return zero
  always_comb begin
    case (s_q.ptr)
      LDS_REG_DECODE: rd_byte = s_q.regs.decode;
      LDS_REG_BRIGHT: rd_byte = s_q.regs.bright;
      LDS_REG_LIMIT: rd_byte = s_q.regs.limit;
      LDS_REG_CONFIG: rd_byte = s_q.regs.config_r;
      LDS_REG_PORTIO: rd_byte = s_q.regs.portio;
      LDS_REG_LAMP: rd_byte = s_q.regs.lamp;
      LDS_REG_KEYSET: rd_byte = i_key_settled;
      LDS_REG_KEYDN: rd_byte = i_key_down;
      LDS_REG_DIGIT0: rd_byte = s_q.regs.digit[0];
      LDS_REG_DIGIT1: rd_byte = s_q.regs.digit[1];
      LDS_REG_DIGIT2: rd_byte = s_q.regs.digit[2];
      LDS_REG_DIGIT3: rd_byte = s_q.regs.digit[3];
      LDS_REG_DISCRETE: rd_byte = s_q.regs.discrete;
      default: rd_byte = 8'h00;
    endcase
  end

  // Hex font: bits a..g as 6..0
  function automatic logic [6:0] hex_font(input logic [3:0] v);
    case (v)
      4'h0: hex_font = 7'h7E;
      4'h1: hex_font = 7'h30;
      4'h2: hex_font = 7'h6D;
      4'h3: hex_font = 7'h79;
      4'h4: hex_font = 7'h33;
      4'h5: hex_font = 7'h5B;
      4'h6: hex_font = 7'h5F;
      4'h7: hex_font = 7'h70;
      4'h8: hex_font = 7'h7F;
      4'h9: hex_font = 7'h7B;
      4'hA: hex_font = 7'h77;
      4'hB: hex_font = 7'h1F;
      4'hC: hex_font = 7'h4E;
      4'hD: hex_font = 7'h3D;
      4'hE: hex_font = 7'h4F;
      default: hex_font = 7'h47;
    endcase
  endfunction

  // Next-state logic
  always_comb begin
    s_d = s_q;
    f_valid = 1'b0;
    fin = '0;
    // Two-stage pin synchronisers, then one delayed copy for edges
    s_d.scl_s = {s_q.scl_s[0], i_scl};
    s_d.sda_s = {s_q.sda_s[0], i_sda};
    s_d.scl_p = s_q.scl_s[1];
    s_d.sda_p = s_q.sda_s[1];

    if (start_c) begin
      s_d.st = LDS_ADDR;
      s_d.bitn = 4'h0;
      s_d.oe = 1'b0;
    end else if (stop_c) begin
      s_d.st = LDS_IDLE;
      s_d.oe = 1'b0;
    end else begin
      case (s_q.st)
        LDS_ADDR, LDS_WRITE: begin
          if (scl_rise) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
            s_d.bitn = s_q.bitn + 4'h1;
          end else if (scl_fall && s_q.bitn == 4'h8) begin
            if (s_q.st == LDS_ADDR) begin
              if (s_q.sh[7:1] == own_addr) begin
                s_d.oe = 1'b1;
                s_d.st = LDS_ACK;
                s_d.first = ~s_q.sh[0];
                // Direction kept apart so later data bytes cannot turn the port
                s_d.rd = s_q.sh[0];
              end else begin
                s_d.st = LDS_SKIP;
              end
            end else if (f_ready) begin
              // Full FIFO withholds the ack so the master sees a refusal
              f_valid = 1'b1;
              fin.is_cmd = s_q.first;
              fin.data = s_q.sh;
              s_d.oe = 1'b1;
              s_d.st = LDS_ACK;
              s_d.first = 1'b0;
            end else begin
              s_d.st = LDS_SKIP;
            end
          end
        end
        LDS_ACK: begin
          if (scl_fall) begin
            s_d.bitn = 4'h0;
            // Only an address ack of a read frame hands the line to the port
            if (s_q.rd) begin
              // Read: first data bit driven at once
              s_d.st = LDS_READ;
              s_d.sh = rd_byte;
              s_d.oe = ~rd_byte[7];
            end else begin
              s_d.st = LDS_WRITE;
              s_d.oe = 1'b0;
            end
          end
        end
        LDS_READ: begin
          if (scl_rise) begin
            s_d.bitn = s_q.bitn + 4'h1;
          end else if (scl_fall) begin
            if (s_q.bitn == 4'h8) begin
              s_d.oe = 1'b0;
              s_d.st = LDS_MACK;
              if (s_q.ptr != LDS_PTR_TOP) s_d.ptr = s_q.ptr + 8'h01;
            end else begin
              s_d.sh = {s_q.sh[6:0], 1'b0};
              s_d.oe = ~s_q.sh[6];
            end
          end
        end
        LDS_MACK: begin
          if (scl_rise) begin
            s_d.bitn = s_q.sda_s[1] ? 4'hF : 4'h0;
          end else if (scl_fall) begin
            if (s_q.bitn == 4'h0) begin
              s_d.st = LDS_READ;
              s_d.sh = rd_byte;
              s_d.oe = ~rd_byte[7];
            end else begin
              s_d.st = LDS_SKIP;
            end
          end
        end
        LDS_SKIP: s_d.oe = 1'b0;
        LDS_IDLE: s_d.oe = 1'b0;
        default: s_d.st = LDS_IDLE;
      endcase
    end

    // Register file update from the FIFO
    if (d_valid) begin
      if (fout.is_cmd) begin
        s_d.ptr = fout.data;
      end else begin
        case (s_q.ptr)
          LDS_REG_DECODE: s_d.regs.decode = fout.data;
          LDS_REG_BRIGHT: s_d.regs.bright = fout.data;
          LDS_REG_LIMIT: s_d.regs.limit = fout.data;
          LDS_REG_CONFIG: s_d.regs.config_r = fout.data;
          LDS_REG_PORTIO: s_d.regs.portio = fout.data;
          LDS_REG_LAMP: s_d.regs.lamp = fout.data;
          LDS_REG_DIGIT0: s_d.regs.digit[0] = fout.data;
          LDS_REG_DIGIT1: s_d.regs.digit[1] = fout.data;
          LDS_REG_DIGIT2: s_d.regs.digit[2] = fout.data;
          LDS_REG_DIGIT3: s_d.regs.digit[3] = fout.data;
          LDS_REG_DISCRETE: s_d.regs.discrete = fout.data;
          default: ;
        endcase
        if (s_q.ptr != LDS_PTR_TOP) s_d.ptr = s_q.ptr + 8'h01;
      end
    end

    // Segment outputs, decoded or direct
    for (int i = 0; i < 4; i++) begin
      if (s_q.regs.decode[i]) begin
        s_d.seg[i] = hex_font(s_q.regs.digit[i][LDS_HEX_MSB:0]);
      end else begin
        s_d.seg[i] = s_q.regs.digit[i][LDS_SEG_MSB:0];
      end
    end
    s_d.disc = s_q.regs.discrete;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
      s_q.scl_s <= 2'b11;
      s_q.sda_s <= 2'b11;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.st <= LDS_IDLE;
      s_q.ptr <= LDS_RST_PTR;
      s_q.regs.decode <= LDS_RST_DECODE;
      s_q.regs.bright <= LDS_RST_BRIGHT;
      s_q.regs.limit <= LDS_RST_LIMIT;
      s_q.regs.config_r <= LDS_RST_CONFIG;
      s_q.regs.portio <= LDS_RST_PORTIO;
      s_q.regs.lamp <= LDS_RST_LAMP;
      s_q.regs.digit <= {4{LDS_RST_DIGIT}};
      s_q.regs.discrete <= LDS_RST_DIGIT;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops except o_sda, tied low, so the data pin is only ever pulled low
  assign o_sda = 1'b0;
  assign o_sda_oe = s_q.oe;
  assign o_digit_seg = s_q.seg;
  assign o_discrete_led = s_q.disc;
  assign o_brightness = s_q.regs.bright;
  assign o_digit_limit = s_q.regs.limit;
  assign o_config = s_q.regs.config_r;
  assign o_port_io = s_q.regs.portio;
  assign o_lamp_test = s_q.regs.lamp;
endmodule

// *** sim/lds_port_checker.sv ***
// Purpose: timing checks on the serial data pin of the register port
// Assumes: bus pins change well away from clock edges
// Notes: frame tracking runs on the raw pins, without synchronisers
module lds_port_checker
  import lds_pkg::*;
#(
  parameter bit ADDRESS_OPTION_BIT = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_q, sda_q, busy_q, first_q, match_q, rd_q, ign_q;
  logic [3:0] bcnt_q;
  logic [7:0] sh_q;
  logic [2:0] idle_q;
  logic start_w, stop_w, rise_w, hit_w;
  // Bus conditions seen one clock apart
  assign start_w = scl_q && i_scl && sda_q && !i_sda;
  assign stop_w = scl_q && i_scl && !sda_q && i_sda;
  assign rise_w = !scl_q && i_scl;
  assign hit_w = sh_q[7:1] == {LDS_ADDR_UPPER, ADDRESS_OPTION_BIT};
  // Frame, bit count and address capture
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {scl_q, sda_q, busy_q, first_q, match_q, rd_q, ign_q} <= 7'h60;
      {bcnt_q, sh_q, idle_q} <= '0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      idle_q <= busy_q ? 3'h0 : idle_q + 3'(idle_q != 3'h7); // Saturates
      if (start_w) begin
        {busy_q, first_q, ign_q} <= 3'h6;
        bcnt_q <= 4'h0;
      end else if (stop_w) begin
        {busy_q, ign_q} <= 2'h0;
      end else if (rise_w && bcnt_q == 4'h8) begin
        bcnt_q <= 4'h0;
        first_q <= 1'b0;
        if (first_q) begin
          {match_q, rd_q, ign_q} <= {hit_w, sh_q[0], !hit_w};
        end
      end else if (rise_w) begin
        bcnt_q <= bcnt_q + 4'h1;
        sh_q <= {sh_q[6:0], i_sda};
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Clock rise of the ninth bit of a byte
  sequence s_ninth;
    busy_q && rise_w && bcnt_q == 4'h8;
  endsequence
  od_low_a: assert property (o_sda == 1'b0) else $error("pin driven high");
  idle_release_a: assert property (idle_q == 3'h7 |-> !o_sda_oe)
    else $error("data held on idle bus");
  high_stable_a: assert property (i_scl && $past(i_scl) && $past(i_scl, 2)
    && $past(i_scl, 3) |-> $stable(o_sda_oe)) else $error("data moved, clock high");
  change_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed while clock high");
  addr_ack_a: assert property (s_ninth ##0 first_q && hit_w |-> o_sda_oe)
    else $error("own address not acked");
  addr_nack_a: assert property (s_ninth ##0 first_q && !hit_w |-> !o_sda_oe)
    else $error("foreign address acked");
  data_ack_a: assert property (s_ninth ##0 !first_q && match_q |-> o_sda_oe == !rd_q)
    else $error("wrong data ack");
  ign_quiet_a: assert property (ign_q |-> !o_sda_oe)
    else $error("data driven when not addressed");
endmodule

bind lds_port lds_port_checker #(.ADDRESS_OPTION_BIT(ADDRESS_OPTION_BIT)) lds_port_checker_inst (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe));

// *** sim/lds_bus_master.sv ***
// Purpose: behavioural master of the 2-wire bus
// Assumes: data line pulled up, so a released line reads high
// Notes: bit is 20 clocks, clock line high for 10; clock stands high when idle
module lds_bus_master (
  // Clock
  input wire logic i_clk,
  // Bus lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_rel
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus, both lines high
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end
  // Step just past a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Start or repeated start
  task automatic start();
    o_sda_rel = 1'b1;
    tick(5);
    o_scl = 1'b1;
    tick(10);
    o_sda_rel = 1'b0;
    tick(10);
    o_scl = 1'b0;
    tick(5);
  endtask
  task automatic stop();
    o_sda_rel = 1'b0;
    tick(5);
    o_scl = 1'b1;
    tick(10);
    o_sda_rel = 1'b1;
    tick(10);
  endtask
  // Eight bits MSB first and the ninth; data moves only with clock low
  task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] r,
      output logic seen);
    logic [8:0] v;
    v = {d, ninth};
    for (int i = 8; i >= 0; i--) begin
      o_sda_rel = v[i];
      tick(5);
      o_scl = 1'b1;
      tick(5);
      if (i > 0) r = {r[6:0], i_sda};
      else seen = i_sda;
      tick(5);
      o_scl = 1'b0;
      tick(5);
    end
  endtask
endmodule

// *** sim/lds_port_tb.sv ***
// Purpose: self-checking bench of the serial register port
// Assumes: address option bit tied low
// Notes: register model in the bench tracks pointer and contents
module lds_port_tb;
  import lds_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = {LDS_ADDR_UPPER, 1'b0};
  localparam logic [6:0] FONT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F,
    7'h70, 7'h7F, 7'h7B, 7'h77, 7'h1F, 7'h4E, 7'h3D, 7'h4F, 7'h47};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_rel, oe;
  logic [7:0] key_set = 8'h00;
  logic [7:0] key_dn = 8'h00;
  logic [3:0][6:0] seg;
  logic [7:0] disc, bright, lim, cfg, pio, lamp;
  logic [7:0] mem [128];
  logic [7:0] q [$];
  wire sda_w = sda_rel & ~oe;
  int ptr, n_mismatch, num_checks;
  // 10 MHz clock
  always #50 clk = ~clk;
  lds_port #(.ADDRESS_OPTION_BIT(1'b0)) lds_port_inst (.i_clk(clk), .i_rstn(rst_n),
    .i_scl(scl), .i_sda(sda_w), .o_sda(), .o_sda_oe(oe), .i_key_settled(key_set),
    .i_key_down(key_dn), .o_digit_seg(seg), .o_discrete_led(disc), .o_brightness(bright),
    .o_digit_limit(lim), .o_config(cfg), .o_port_io(pio), .o_lamp_test(lamp));
  lds_bus_master lds_bus_master_inst (.i_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda_rel(sda_rel));
  function automatic logic [7:0] rb();
    return 8'($urandom);
  endfunction
  function automatic bit wable(int p);
    return (p >= 1 && p <= 7 && p != 5) || (p >= 32 && p <= 36);
  endfunction
  function automatic logic [7:0] mread(int p);
    return p == 8 ? key_set : p == 12 ? key_dn : wable(p) ? mem[p] : 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Display and control outputs against the model
  task automatic chk_out();
    logic [6:0] e;
    for (int i = 0; i < 4; i++) begin
      e = mem[1][i] ? FONT[mem[32 + i][3:0]] : mem[32 + i][6:0];
      chk("digit", {1'b0, e}, {1'b0, seg[i]});
    end
    chk("discrete", mem[36], disc);
    chk("bright", mem[2], bright);
    chk("limit", mem[3], lim);
    chk("config", mem[4], cfg);
    chk("portio", mem[6], pio);
    chk("lamp", mem[7], lamp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] b [$], input bit fin);
    logic [7:0] r;
    logic s;
    bit hit;
    hit = a == DEV;
    lds_bus_master_inst.start();
    lds_bus_master_inst.xfer({a, 1'b0}, 1'b1, r, s);
    chk("address ack", {7'h00, !hit}, {7'h00, s});
    foreach (b[k]) begin
      lds_bus_master_inst.xfer(b[k], 1'b1, r, s);
      chk("write ack", {7'h00, !hit}, {7'h00, s});
      if (hit && k == 0) ptr = b[k];
      else if (hit) begin
        if (wable(ptr)) mem[ptr] = b[k];
        ptr += (ptr != 127);
      end
    end
    if (fin) lds_bus_master_inst.stop();
    lds_bus_master_inst.tick(4);
  endtask
  task automatic rd(input int n);
    logic [7:0] r;
    logic s;
    lds_bus_master_inst.start();
    lds_bus_master_inst.xfer({DEV, 1'b1}, 1'b1, r, s);
    chk("read address ack", 8'h00, {7'h00, s});
    for (int k = 0; k < n; k++) begin
      lds_bus_master_inst.xfer(8'hFF, k == n - 1, r, s);
      chk("read data", mread(ptr), r);
      ptr += (ptr != 127);
    end
    lds_bus_master_inst.stop();
  endtask
  // Watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {mem[1], mem[2], mem[3]} = {LDS_RST_DECODE, LDS_RST_BRIGHT, LDS_RST_LIMIT};
    {mem[4], mem[6], mem[7]} = {LDS_RST_CONFIG, LDS_RST_PORTIO, LDS_RST_LAMP};
    for (int p = 32; p < 37; p++) mem[p] = LDS_RST_DIGIT;
    ptr = LDS_RST_PTR;
    void'($urandom(32'h91FD));
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    lds_bus_master_inst.tick(4);
    chk_out();
    // Control registers, stepping over the reserved location
    wr(DEV, {LDS_REG_DECODE, rb(), rb(), rb(), rb()}, 1);
    wr(DEV, {LDS_REG_PORTIO, rb(), rb()}, 1);
    wr(DEV, {LDS_REG_DECODE}, 1);
    chk_out();
    rd(7);
    // Display burst, then readback over a repeated start
    wr(DEV, {LDS_REG_DIGIT0, rb(), rb(), rb(), rb(), rb()}, 1);
    chk_out();
    wr(DEV, {LDS_REG_DIGIT0}, 0);
    rd(5);
    // Every hex value, decode off for 4, 9, C and D, upper nibble random
    for (int k = 0; k < 4; k++) begin
      wr(DEV, {LDS_REG_DECODE, 8'h0F ^ 8'(k)}, 1);
      q = {LDS_REG_DIGIT0};
      for (int i = 0; i < 4; i++) q.push_back((rb() & 8'hF0) | 8'(4 * k + i));
      wr(DEV, q, 1);
      chk_out();
    end
    // Pointer holds at its top value
    wr(DEV, {8'h7E, rb(), rb(), rb()}, 1);
    rd(3);
    // Status registers ignore writes
    key_set = rb();
    key_dn = rb();
    wr(DEV, {LDS_REG_LAMP, rb(), rb(), rb(), rb(), rb(), rb()}, 0);
    wr(DEV, {LDS_REG_LAMP}, 0);
    rd(6);
    // Foreign address leaves everything alone
    wr({LDS_ADDR_UPPER, 1'b1}, {LDS_REG_DIGIT0, rb(), rb()}, 1);
    chk_out();
    report_and_stop();
  end
endmodule
